// [src/nvac_access_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module nvac_access_ctrl #(
    parameter int WR_OSC_CYCLES = nvac_pkg::NVAC_WR_OSC_CYCLES
) (
    // Clock and resets.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic por_b,
    // CPU register port.
    input wire nvac_pkg::nvac_io_req_s io_req,
    output logic [7:0] io_rdata,
    // Core status and control.
    input wire logic global_irq_enable,
    input wire logic self_program_active,
    output logic cpu_stall,
    output logic ready_irq,
    output logic write_busy,
    // Calibrated 1 MHz oscillator pin.
    input wire logic rc_osc_1mhz
);
    import nvac_pkg::*;

    // Array storage, plain flip-flops with no reset.
    logic [7:0] mem [NVAC_DEPTH];

    // CPU side state, cleared by the CPU reset.
    logic [8:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic rie_r, rie_nxt;
    logic [2:0] mwe_cnt_r, mwe_cnt_nxt;
    logic [2:0] stall_r, stall_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Write engine state, cleared only at power-on so a write survives.
    nvac_wst_e wst_r, wst_nxt;
    logic [NVAC_TMR_W-1:0] tmr_r, tmr_nxt;
    logic [8:0] wa_r, wa_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic osc_meta_r, osc_sync_r, osc_prev_r;

    logic busy, osc_tick, ctrl_wr, start, rd_go, done;

    assign busy = (wst_r == NVAC_PROG);
    // Only the second stage feeds the edge detector.
    assign osc_tick = osc_sync_r & ~osc_prev_r;
    assign ctrl_wr = io_req.wr && (io_req.sel == NVAC_IDX_CTRL);
    // A strobe counts only inside the master enable window and when idle.
    assign start = ctrl_wr && io_req.wdata[NVAC_BIT_WE] && (mwe_cnt_r != 3'h0)
        && !busy && !self_program_active;
    // Reads are dropped while a write runs.
    assign rd_go = ctrl_wr && io_req.wdata[NVAC_BIT_RE] && !busy;
    assign done = busy && osc_tick
        && (tmr_r == NVAC_TMR_W'(WR_OSC_CYCLES - 1));

    // Outputs.
    assign io_rdata = rdata_r;
    assign cpu_stall = (stall_r != 3'h0);
    assign write_busy = busy;
    // Level interrupt while idle; no flag to clear.
    assign ready_irq = rie_r && global_irq_enable && !busy;

    // CPU side next values.
    always_comb begin
        addr_nxt = addr_r;
        data_nxt = data_r;
        rie_nxt = rie_r;
        mwe_cnt_nxt = (mwe_cnt_r != 3'h0) ? mwe_cnt_r - 3'h1 : 3'h0;
        stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
        rdata_nxt = rdata_r;
        if (io_req.wr) begin
            if (io_req.sel == NVAC_IDX_ADDR_LO) begin
                if (!busy) begin
                    addr_nxt[7:0] = io_req.wdata;
                end
            end else if (io_req.sel == NVAC_IDX_ADDR_HI) begin
                if (!busy) begin
                    addr_nxt[8] = io_req.wdata[0];
                end
            end else if (io_req.sel == NVAC_IDX_DATA) begin
                data_nxt = io_req.wdata;
            end else begin
                rie_nxt = io_req.wdata[NVAC_BIT_RIE];
                if (io_req.wdata[NVAC_BIT_MWE]) begin
                    mwe_cnt_nxt = NVAC_MWE_CYCLES;
                end
            end
        end
        if (rd_go) begin
            data_nxt = mem[addr_r];
            stall_nxt = NVAC_RD_STALL;
        end
        if (start) begin
            stall_nxt = NVAC_WR_STALL;
        end
        // Readback; unused bits are zero.
        if (io_req.rd) begin
            if (io_req.sel == NVAC_IDX_ADDR_LO) begin
                rdata_nxt = addr_r[7:0];
            end else if (io_req.sel == NVAC_IDX_ADDR_HI) begin
                rdata_nxt = {7'h00, addr_r[8]};
            end else if (io_req.sel == NVAC_IDX_DATA) begin
                rdata_nxt = data_r;
            end else begin
                rdata_nxt = {4'h0, rie_r, (mwe_cnt_r != 3'h0), busy,
                    1'b0};
            end
        end
    end

    // CPU side registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= NVAC_ADDR_RST;
            data_r <= NVAC_DATA_RST;
            rie_r <= 1'b0;
            mwe_cnt_r <= 3'h0;
            stall_r <= 3'h0;
            rdata_r <= 8'h00;
        end else begin
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            rie_r <= rie_nxt;
            mwe_cnt_r <= mwe_cnt_nxt;
            stall_r <= stall_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Write engine next values; address and data are captured at start
    // so a later register change cannot corrupt a write in flight.
    always_comb begin
        wst_nxt = wst_r;
        tmr_nxt = tmr_r;
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        case (wst_r)
            NVAC_IDLE: begin
                if (start) begin
                    wst_nxt = NVAC_PROG;
                    tmr_nxt = '0;
                    wa_nxt = addr_r;
                    wd_nxt = data_r;
                end
            end
            NVAC_PROG: begin
                if (done) begin
                    wst_nxt = NVAC_IDLE;
                end else if (osc_tick) begin
                    tmr_nxt = tmr_r + NVAC_TMR_W'(1);
                end
            end
            default: begin
                wst_nxt = NVAC_IDLE;
            end
        endcase
    end

    // Write engine registers; the CPU reset is not wired here.
    always_ff @(posedge core_clk or negedge por_b) begin
        if (!por_b) begin
            wst_r <= NVAC_IDLE;
            tmr_r <= '0;
            wa_r <= NVAC_ADDR_RST;
            wd_r <= NVAC_DATA_RST;
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            wst_r <= wst_nxt;
            tmr_r <= tmr_nxt;
            wa_r <= wa_nxt;
            wd_r <= wd_nxt;
            osc_meta_r <= rc_osc_1mhz;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    // The byte lands in the array when the write time is over.
    always_ff @(posedge core_clk) begin
        if (done) begin
            mem[wa_r] <= wd_r;
        end
    end

    sequence s_stall2;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence

    sequence s_stall4;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence

    // A master enable left alone must be gone on the fifth edge after it.
    a_mwe_auto_clear: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (ctrl_wr && io_req.wdata[NVAC_BIT_MWE])
        ##1 !(ctrl_wr && io_req.wdata[NVAC_BIT_MWE]) [*4]
        |=> (mwe_cnt_r == 3'h0))
        else $error("master enable window not closed");
    a_mwe_four: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ctrl_wr && io_req.wdata[NVAC_BIT_MWE] && !io_req.wdata[NVAC_BIT_WE]
        && !$past(ctrl_wr) |=> (mwe_cnt_r == 3'h4) ##3 (mwe_cnt_r == 3'h1))
        else $error("master enable does not run four cycles");
    a_start_needs_mwe: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $rose(busy) |-> $past(mwe_cnt_r != 3'h0))
        else $error("write started without master enable");
    a_no_flash_clash: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $rose(busy) |-> !$past(self_program_active))
        else $error("write started during flash programming");
    a_irq_level: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ready_irq == (rie_r && global_irq_enable && !busy))
        else $error("ready interrupt level wrong");
    a_wr_stall: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $rose(busy) |-> s_stall2)
        else $error("write stall not two cycles");
    a_rd_stall: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        rd_go |=> s_stall4)
        else $error("read stall not four cycles");
    a_rd_data: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        rd_go |=> data_r == mem[$past(addr_r)])
        else $error("read did not load addressed byte");
    a_addr_frozen: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        busy |=> $stable(addr_r) || !$past(busy))
        else $error("address changed during write");
    a_busy_clears: assert property (@(posedge core_clk)
        disable iff (!por_b)
        done |=> !busy)
        else $error("busy not cleared at write end");

endmodule : nvac_access_ctrl
`default_nettype wire

// [src/nvac_pkg.sv]
// How it works
// - A 9-bit address, high bit and low byte, picks one byte of 0 to 511.
// - Address bits 15..9 and control bits 7..4 always read back as zero.
// - A write stores the data byte at the address; a read fetches it back.
// - Both enables set, a level interrupt stands while the strobe is zero.
// - A strobe starts a write only within four cycles of the master enable.
// - The master enable clears itself four cycles after software sets it.
// - No array write starts while the CPU is programming its own Flash.
// - The write strobe reads one while a write runs and clears at its end.
// - Starting a write halts the CPU for two cycles.
// - A read strobe loads the data at once and halts the CPU four cycles.
// - During a write, read strobes and address writes are ignored.
// - A write lasts 8448 ticks of the 1 MHz oscillator, not CPU clocks.
// - A write in progress still completes across a CPU reset.
package nvac_pkg;

    // Register indices on the I/O port.
    localparam logic [1:0] NVAC_IDX_ADDR_LO = 2'h0;
    localparam logic [1:0] NVAC_IDX_ADDR_HI = 2'h1;
    localparam logic [1:0] NVAC_IDX_DATA = 2'h2;
    localparam logic [1:0] NVAC_IDX_CTRL = 2'h3;

    // Control register bit positions.
    localparam int NVAC_BIT_RIE = 3;
    localparam int NVAC_BIT_MWE = 2;
    localparam int NVAC_BIT_WE = 1;
    localparam int NVAC_BIT_RE = 0;

    // Sizes and reset values.
    localparam int NVAC_ADDR_W = 9;
    localparam int NVAC_DEPTH = 512;
    localparam logic [8:0] NVAC_ADDR_RST = 9'h000;
    localparam logic [7:0] NVAC_DATA_RST = 8'h00;

    // Timing counts in core clock cycles; the write time counts oscillator ticks.
    localparam logic [2:0] NVAC_MWE_CYCLES = 3'h4;
    localparam logic [2:0] NVAC_WR_STALL = 3'h2;
    localparam logic [2:0] NVAC_RD_STALL = 3'h4;
    localparam int NVAC_WR_OSC_CYCLES = 8448;
    localparam int NVAC_TMR_W = 14;

    // One register access from the CPU.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [7:0] wdata;
    } nvac_io_req_s;

    // Write engine states.
    typedef enum logic [1:0] {
        NVAC_IDLE = 2'b01,
        NVAC_PROG = 2'b10
    } nvac_wst_e;

endpackage : nvac_pkg

// [tb/nvac_access_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module nvac_access_ctrl_tb;
    import nvac_pkg::*;

    // Short write time keeps the run brief; bounds below are fixed counts sized for it.
    localparam int OSC_N = 4;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic rc_osc_1mhz = 1'b0;
    logic global_irq_enable = 1'b0;
    logic self_program_active = 1'b0;
    nvac_io_req_s io_req = '0;
    logic [7:0] io_rdata;
    logic cpu_stall;
    logic ready_irq;
    logic write_busy;
    int fails = 0;
    int check_count = 0;
    int stalls = 0;
    int s0 = 0;

    nvac_access_ctrl #(.WR_OSC_CYCLES(OSC_N)) i_nvac_access_ctrl (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .por_b(por_b),
        .io_req(io_req),
        .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable),
        .self_program_active(self_program_active),
        .cpu_stall(cpu_stall),
        .ready_irq(ready_irq),
        .write_busy(write_busy),
        .rc_osc_1mhz(rc_osc_1mhz)
    );

    // Core clock at 125 MHz.
    always #4 core_clk = ~core_clk;

    // Oscillator offset in phase so its edges never meet the core clock.
    initial begin
        #3;
        forever #500 rc_osc_1mhz = ~rc_osc_1mhz;
    end

    // Counts halted cycles so each access can measure its own stall.
    always @(posedge core_clk) begin
        if (cpu_stall === 1'b1) stalls++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // One access, then no new request until the core is released.
    task automatic put(input logic w, input logic r, input logic [1:0] s,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        io_req <= '{wr: w, rd: r, sel: s, wdata: d};
        @(posedge core_clk);
        io_req <= '0;
        @(posedge core_clk);
        #1;
        while (cpu_stall !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({7'h0, cpu_stall}, 8'h00);
    endtask : put

    task automatic rd(input logic [1:0] s, input logic [7:0] exp);
        put(1'b0, 1'b1, s, 8'h00);
        check(io_rdata, exp);
    endtask : rd

    // The limit sits well below the full-length write time.
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 1000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({7'h0, write_busy}, 8'h00);
    endtask : wait_idle

    task automatic set_addr(input logic [8:0] a);
        put(1'b1, 1'b0, NVAC_IDX_ADDR_HI, {7'h0, a[8]});
        put(1'b1, 1'b0, NVAC_IDX_ADDR_LO, a[7:0]);
    endtask : set_addr

    // Interrupts stay off across the timed pair, so the window cannot lapse.
    task automatic start_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        global_irq_enable <= 1'b0;
        set_addr(a);
        put(1'b1, 1'b0, NVAC_IDX_DATA, d);
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h0c);
        s0 = stalls;
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h0a);
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
    endtask : start_wr

    task automatic rd_byte(input logic [8:0] a, input logic [7:0] exp);
        set_addr(a);
        s0 = stalls;
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h01);
        check(8'(stalls - s0), 8'h04);
        rd(NVAC_IDX_DATA, exp);
    endtask : rd_byte

    // Cuts a hang short; the whole run needs well under this.
    initial begin
        #200000;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd(NVAC_IDX_CTRL, 8'h00);
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'hf8);
        rd(NVAC_IDX_CTRL, 8'h08);
        put(1'b1, 1'b0, NVAC_IDX_ADDR_HI, 8'hff);
        rd(NVAC_IDX_ADDR_HI, 8'h01);
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h04);
        rd(NVAC_IDX_CTRL, 8'h04);
        repeat (6) @(posedge core_clk);
        rd(NVAC_IDX_CTRL, 8'h00);
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h02);
        check({7'h0, write_busy}, 8'h00);
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        start_wr(9'h1ff, 8'ha5);
        check(8'(stalls - s0), 8'h02);
        check({7'h0, write_busy}, 8'h01);
        rd(NVAC_IDX_CTRL, 8'h0a);
        check({7'h0, ready_irq}, 8'h00);
        put(1'b1, 1'b0, NVAC_IDX_ADDR_LO, 8'h00);
        put(1'b1, 1'b0, NVAC_IDX_DATA, 8'h3c);
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h09);
        rd(NVAC_IDX_DATA, 8'h3c);
        rd(NVAC_IDX_ADDR_LO, 8'hff);
        repeat (300) @(posedge core_clk);
        check({7'h0, write_busy}, 8'h01);
        wait_idle();
        check({7'h0, ready_irq}, 8'h01);
        @(posedge core_clk);
        global_irq_enable <= 1'b0;
        @(posedge core_clk);
        #1;
        check({7'h0, ready_irq}, 8'h00);
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        put(1'b1, 1'b0, NVAC_IDX_CTRL, 8'h00);
        check({7'h0, ready_irq}, 8'h00);
        start_wr(9'h0ff, 8'h5a);
        wait_idle();
        rd_byte(9'h1ff, 8'ha5);
        rd_byte(9'h0ff, 8'h5a);
        // A write must not start while the core programs its own flash.
        @(posedge core_clk);
        self_program_active <= 1'b1;
        start_wr(9'h0ff, 8'h11);
        check({7'h0, write_busy}, 8'h00);
        @(posedge core_clk);
        self_program_active <= 1'b0;
        rd_byte(9'h0ff, 8'h5a);
        // A core reset in mid-write must not cut the write short.
        start_wr(9'h000, 8'h77);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        check({7'h0, write_busy}, 8'h01);
        wait_idle();
        rd_byte(9'h000, 8'h77);
        print_verdict();
    end

endmodule : nvac_access_ctrl_tb
`default_nettype wire
